// ==== design/cwl_loader.v ====
// Configuration word loader and word 1 decoder
// Overview of operation
// R1: Programmed bit reads zero, erased bit reads one, selecting one-valued option.
// R2: Configuration bits appear in configuration space from F80000h upward.
// R3: Region 800000h-FFFFFFh answers table accesses only, never data accesses.
// R4: Configuration registers are volatile and invalid until loaded.
// R5: Every device reset copies the flash words into the configuration registers.
// R6: Word 1 at ABFEh or 157FEh, later words two addresses lower.
// R7: Software writes zero upper bytes; the device ignores them.
// R8: Erasing the last page clears the words, enabling code protection.
// R9: Word 1 bits 23-16 read one; bit 15 reserved, program zero.
// R10: Bit 14 one enables boundary-scan port, zero disables.
// R11: Bit 13 zero protects all program memory code.
// R12: Bit 12 zero blocks all program memory writes.
// R13: Bit 11 zero resets into debug state, one into normal operation.
// R14: Bit 10 one keeps retention regulator off; zero gives firmware control.
// R15: Bits 9-8 route emulator to pin pair 1, 2, 3; 00 reserved.
// R16: Bit 7 one standard watchdog, zero windowed; windowed needs nonzero field.
// R17: Bits 6-5 pick watchdog always on, software, run-only or disabled.
// R18: Bit 4 picks watchdog prescaler 1:128 when one, 1:32 when zero.
// R19: Software must reserve configuration word locations in its builds.
// R20: Bits 3-0 pick watchdog postscaler two to the power of code.
// R21: Rest of device held in reset until all registers are loaded.
`timescale 1ns/100ps
`include "cwl_defines.vh"
module cwl_loader (
  clk,
  reset,
  large_variant,
  flash_addr,
  flash_rd,
  flash_data,
  last_page_erase,
  tbl_addr,
  tbl_rd,
  tbl_wr,
  tbl_wdata,
  tbl_rdata,
  tbl_hit,
  data_addr,
  data_cfg_blocked,
  load_busy,
  device_reset_hold,
  config_word_one,
  boundary_scan_port_enable,
  general_code_protect,
  general_write_protect,
  debug_boot,
  retention_regulator_config,
  retention_regulator_allowed,
  emulator_pin_pair_select,
  programming_pin_pair_one,
  programming_pin_pair_two,
  programming_pin_pair_three,
  emulator_select_invalid,
  windowed_watchdog_disable,
  watchdog_config_field,
  watchdog_software_enable,
  watchdog_enable_run,
  watchdog_enable_sleep,
  watchdog_window_invalid,
  watchdog_prescale_select,
  watchdog_prescale_ratio,
  watchdog_postscale_select,
  watchdog_postscale_ratio
);
  input clk;
  input reset;
  input large_variant;
  output [16:0] flash_addr;
  output flash_rd;
  input [23:0] flash_data;
  input last_page_erase;
  input [23:0] tbl_addr;
  input tbl_rd;
  input tbl_wr;
  input [23:0] tbl_wdata;
  output [23:0] tbl_rdata;
  output tbl_hit;
  input [23:0] data_addr;
  output data_cfg_blocked;
  output load_busy;
  output device_reset_hold;
  output [23:0] config_word_one;
  output boundary_scan_port_enable;
  output general_code_protect;
  output general_write_protect;
  output debug_boot;
  output retention_regulator_config;
  output retention_regulator_allowed;
  output [1:0] emulator_pin_pair_select;
  output programming_pin_pair_one;
  output programming_pin_pair_two;
  output programming_pin_pair_three;
  output emulator_select_invalid;
  output windowed_watchdog_disable;
  output [1:0] watchdog_config_field;
  input watchdog_software_enable;
  output watchdog_enable_run;
  output watchdog_enable_sleep;
  output watchdog_window_invalid;
  output watchdog_prescale_select;
  output [7:0] watchdog_prescale_ratio;
  output [3:0] watchdog_postscale_select;
  output [15:0] watchdog_postscale_ratio;
  wire clk;
  wire reset;
  wire large_variant;
  wire [23:0] flash_data;
  wire last_page_erase;
  wire [23:0] tbl_addr;
  wire tbl_rd;
  wire tbl_wr;
  wire [23:0] tbl_wdata;
  wire [23:0] data_addr;
  wire watchdog_software_enable;
  wire [23:0] tbl_rdata;
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DONE = 2'h3;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] idx_r;
  reg [2:0] idx_nxt;
  reg [23:0] cw1_r;
  reg valid_r;
  reg tbl_hit_r;
  wire [16:0] base_addr;
  wire [1:0] rd_idx;
  wire [23:0] store_rd;
  wire store_wr;
  wire [23:0] cw1;
  wire [23:0] load_word;
  wire [23:0] cfg_base;
  wire tbl_cfg_rd;
  wire [23:0] store_word;
  reg tbl_word1_r;
  reg [2:0] emu_pair_dec;
  reg emu_rsvd_dec;
  reg wdt_run_dec;
  reg wdt_sleep_dec;
  // ****************************************
  // Load sequencer
  // ****************************************
  assign base_addr = large_variant ? `CWL_CW1_ADDR_LARGE : `CWL_CW1_ADDR_SMALL; // [R6]
  assign flash_addr = base_addr - ({14'h0000, idx_r} * `CWL_CW_STEP); // [R6]
  assign flash_rd = (state_r == ST_READ);
  assign store_wr = (state_r == ST_WAIT);
  assign load_busy = (state_r != ST_DONE);
  assign device_reset_hold = load_busy; // [R21]
  always @* begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      ST_IDLE: begin
        state_nxt = ST_READ;
      end
      ST_READ: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (idx_r == (`CWL_CW_COUNT - 3'h1)) begin
          state_nxt = ST_DONE;
        end else begin
          idx_nxt = idx_r + 3'h1;
          state_nxt = ST_READ;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end
  // Every reset restarts the copy from word 1
  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE; // [R5]
      idx_r <= 3'h0;
      cw1_r <= `CWL_CW_ERASED;
      valid_r <= 1'b0; // [R4]
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      if (store_wr && (idx_r == 3'h0)) begin
        cw1_r <= load_word; // [R5]
      end
      if (store_wr && (state_nxt == ST_DONE)) begin
        valid_r <= 1'b1;
      end
    end
  end
  // A cleared last page loads as all zeros, so code protection follows
  assign load_word = last_page_erase ? 24'h000000 : flash_data; // [R8]
  cwl_word_store u_store (
    .clk(clk),
    .reset(reset),
    .wr_en(store_wr),
    .wr_idx(idx_r[1:0]),
    .wr_data(load_word),
    .rd_idx(rd_idx),
    .rd_data(store_rd)
  );
  // ****************************************
  // Table access to configuration space
  // ****************************************
  assign cfg_base = `CWL_CFG_SPACE_BASE;
  assign tbl_cfg_rd = tbl_rd && (tbl_addr[23:3] == cfg_base[23:3]); // [R2] [R3]
  assign rd_idx = tbl_addr[2:1];
  assign data_cfg_blocked = data_addr[`CWL_CFG_REGION_MSB]; // [R3]
  assign tbl_hit = tbl_hit_r;
  always @(posedge clk) begin
    if (reset) begin
      tbl_hit_r <= 1'b0;
      tbl_word1_r <= 1'b0;
    end else begin
      tbl_hit_r <= tbl_cfg_rd; // [R2]
      tbl_word1_r <= tbl_cfg_rd && (rd_idx == 2'h0);
    end
  end
  // Later words come from the store and read erased until the load is done
  assign store_word = valid_r ? {`CWL_CW1_UPPER_ONES, store_rd[15:0]} :
    `CWL_CW_ERASED; // [R4]
  assign tbl_rdata = tbl_hit_r ? (tbl_word1_r ? cw1 : store_word) : 24'h000000; // [R2]
  // ****************************************
  // Word 1 decode
  // ****************************************
  // Upper byte forced to ones, written value ignored [R7] [R9]
  assign cw1 = valid_r ? {`CWL_CW1_UPPER_ONES, cw1_r[15:0]} : `CWL_CW_ERASED; // [R1] [R9]
  assign config_word_one = cw1;
  assign boundary_scan_port_enable = cw1[`CWL_BIT_SCAN]; // [R10]
  assign general_code_protect = ~cw1[`CWL_BIT_GCP]; // [R11]
  assign general_write_protect = ~cw1[`CWL_BIT_GWP]; // [R12]
  assign debug_boot = ~cw1[`CWL_BIT_DBG]; // [R13]
  assign retention_regulator_config = cw1[`CWL_BIT_RET];
  assign retention_regulator_allowed = ~cw1[`CWL_BIT_RET]; // [R14]
  assign emulator_pin_pair_select = cw1[`CWL_ICS_HI:`CWL_ICS_LO];
  // ****************************************
  // Emulator placement and watchdog mode decode
  // ****************************************
  always @* begin
    emu_pair_dec = 3'h0;
    emu_rsvd_dec = 1'b0;
    case (emulator_pin_pair_select)
      2'h3: begin
        emu_pair_dec = 3'h1; // [R15]
      end
      2'h2: begin
        emu_pair_dec = 3'h2; // [R15]
      end
      2'h1: begin
        emu_pair_dec = 3'h4; // [R15]
      end
      `CWL_ICS_RSVD: begin
        emu_rsvd_dec = 1'b1; // [R15]
      end
      default: begin
        emu_rsvd_dec = 1'b1;
      end
    endcase
  end
  assign programming_pin_pair_one = emu_pair_dec[0];
  assign programming_pin_pair_two = emu_pair_dec[1];
  assign programming_pin_pair_three = emu_pair_dec[2];
  assign emulator_select_invalid = emu_rsvd_dec;
  assign windowed_watchdog_disable = cw1[`CWL_BIT_WIN]; // [R16]
  assign watchdog_config_field = cw1[`CWL_WDT_HI:`CWL_WDT_LO];
  assign watchdog_window_invalid = ~windowed_watchdog_disable &&
    (watchdog_config_field == `CWL_WDT_OFF); // [R16]
  always @* begin
    wdt_run_dec = 1'b0;
    wdt_sleep_dec = 1'b0;
    case (watchdog_config_field)
      `CWL_WDT_ALWAYS: begin
        wdt_run_dec = 1'b1; // [R17]
        wdt_sleep_dec = 1'b1;
      end
      `CWL_WDT_SW: begin
        wdt_run_dec = watchdog_software_enable; // [R17]
        wdt_sleep_dec = watchdog_software_enable;
      end
      `CWL_WDT_RUN: begin
        wdt_run_dec = 1'b1; // [R17]
      end
      `CWL_WDT_OFF: begin
        wdt_run_dec = 1'b0; // [R17]
      end
      default: begin
        wdt_run_dec = 1'b0;
      end
    endcase
  end
  assign watchdog_enable_run = wdt_run_dec;
  assign watchdog_enable_sleep = wdt_sleep_dec;
  assign watchdog_prescale_select = cw1[`CWL_BIT_PSA];
  assign watchdog_prescale_ratio = watchdog_prescale_select ?
    `CWL_PRESCALE_128 : `CWL_PRESCALE_32; // [R18]
  assign watchdog_postscale_select = cw1[`CWL_PS_HI:`CWL_PS_LO];
  assign watchdog_postscale_ratio = 16'h0001 << watchdog_postscale_select; // [R20]
endmodule // cwl_loader

// ==== design/cwl_defines.vh ====
// Constants for the configuration word loader
`ifndef CWL_DEFINES_VH
`define CWL_DEFINES_VH
`define CWL_FLASH_AW 17
`define CWL_CW1_ADDR_SMALL 17'h0abfe
`define CWL_CW1_ADDR_LARGE 17'h157fe
`define CWL_CW_STEP 17'h00002
`define CWL_CW_COUNT 3'h4
`define CWL_CFG_SPACE_BASE 24'hf80000
`define CWL_CFG_REGION_MSB 23
`define CWL_CW_ERASED 24'hffffff
`define CWL_CW1_UPPER_ONES 8'hff
`define CWL_BIT_RSVD 15
`define CWL_BIT_SCAN 14
`define CWL_BIT_GCP 13
`define CWL_BIT_GWP 12
`define CWL_BIT_DBG 11
`define CWL_BIT_RET 10
`define CWL_ICS_HI 9
`define CWL_ICS_LO 8
`define CWL_BIT_WIN 7
`define CWL_WDT_HI 6
`define CWL_WDT_LO 5
`define CWL_BIT_PSA 4
`define CWL_PS_HI 3
`define CWL_PS_LO 0
`define CWL_WDT_ALWAYS 2'h3
`define CWL_WDT_SW 2'h2
`define CWL_WDT_RUN 2'h1
`define CWL_WDT_OFF 2'h0
`define CWL_ICS_RSVD 2'h0
`define CWL_PRESCALE_128 8'h80
`define CWL_PRESCALE_32 8'h20
`endif

// ==== design/cwl_word_store.v ====
// Configuration word store with registered read data
`timescale 1ns/100ps
`include "cwl_defines.vh"
module cwl_word_store (
  clk,
  reset,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  input clk;
  input reset;
  input wr_en;
  input [1:0] wr_idx;
  input [23:0] wr_data;
  input [1:0] rd_idx;
  output [23:0] rd_data;
  wire clk;
  wire reset;
  wire wr_en;
  wire [1:0] wr_idx;
  wire [23:0] wr_data;
  wire [1:0] rd_idx;
  reg [23:0] rd_data;
  reg [23:0] mem_r [0:3];
  integer i;
  // ****************************************
  // Volatile storage, erased state after reset
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_r[i] <= `CWL_CW_ERASED;
      end
      rd_data <= `CWL_CW_ERASED;
    end else begin
      if (wr_en) begin
        mem_r[wr_idx] <= wr_data;
      end
      rd_data <= mem_r[rd_idx];
    end
  end
endmodule // cwl_word_store

// ==== tb/cwl_loader_props.sv ====
// Port assertions for the configuration word loader
`timescale 1ns/100ps
module cwl_loader_props (
  input wire clk,
  input wire reset,
  input wire tbl_rd,
  input wire [23:0] tbl_addr,
  input wire [23:0] tbl_rdata,
  input wire tbl_hit,
  input wire [23:0] data_addr,
  input wire data_cfg_blocked,
  input wire device_reset_hold,
  input wire [23:0] config_word_one,
  input wire boundary_scan_port_enable,
  input wire general_code_protect,
  input wire debug_boot,
  input wire programming_pin_pair_one,
  input wire [1:0] watchdog_config_field,
  input wire watchdog_software_enable,
  input wire watchdog_enable_run,
  input wire [7:0] watchdog_prescale_ratio,
  input wire [15:0] watchdog_postscale_ratio
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  hold_release_a:
    assert property ($fell(reset) |-> device_reset_hold[*7] ##[1:5] !device_reset_hold)
    else $error("Hold length wrong");
  cfg_upper_a:
    assert property (!device_reset_hold |-> config_word_one[23:16] == 8'hff)
    else $error("Upper byte wrong");
  scan_prot_a:
    assert property (boundary_scan_port_enable == config_word_one[14] &&
      general_code_protect != config_word_one[13] && debug_boot != config_word_one[11])
    else $error("Scan or protect decode wrong");
  pin_pair_a:
    assert property (programming_pin_pair_one == (config_word_one[9:8] == 2'h3))
    else $error("Pin pair decode wrong");
  wdt_run_a:
    assert property (watchdog_enable_run == (watchdog_config_field[0] ||
      (watchdog_config_field == 2'h2 && watchdog_software_enable)))
    else $error("Watchdog run enable wrong");
  wdt_scale_a:
    assert property (watchdog_prescale_ratio == (config_word_one[4] ? 8'h80 : 8'h20) &&
      watchdog_postscale_ratio == (16'h1 << config_word_one[3:0]))
    else $error("Watchdog scaler wrong");
  tbl_hit_a:
    assert property (tbl_rd && tbl_addr == 24'hf80000 |=>
      tbl_hit && tbl_rdata == $past(config_word_one))
    else $error("Table read wrong");
  data_block_a:
    assert property (data_cfg_blocked == data_addr[23])
    else $error("Data block wrong");
endmodule // cwl_loader_props
bind cwl_loader cwl_loader_props u_props (.*);

// ==== tb/tb_cwl_loader.sv ====
// Self-checking bench for the configuration word loader
`timescale 1ns/100ps
module tb_cwl_loader;
  reg clk, reset, large_variant, last_page_erase, tbl_rd, tbl_wr, watchdog_software_enable;
  reg [23:0] tbl_addr, tbl_wdata, data_addr, flash_data, w1, w_eff;
  reg [31:0] rnd;
  reg [2:0] rd_cnt;
  integer num_errors, samples_checked, i, n;
  wire flash_rd, tbl_hit, data_cfg_blocked, load_busy, device_reset_hold, debug_boot;
  wire boundary_scan_port_enable, general_code_protect, general_write_protect;
  wire retention_regulator_config, retention_regulator_allowed, emulator_select_invalid;
  wire programming_pin_pair_one, programming_pin_pair_two, programming_pin_pair_three;
  wire windowed_watchdog_disable, watchdog_enable_run, watchdog_enable_sleep;
  wire watchdog_window_invalid, watchdog_prescale_select;
  wire [1:0] emulator_pin_pair_select, watchdog_config_field;
  wire [3:0] watchdog_postscale_select;
  wire [7:0] watchdog_prescale_ratio;
  wire [15:0] watchdog_postscale_ratio;
  wire [16:0] flash_addr;
  wire [23:0] tbl_rdata, config_word_one;
  wire [16:0] base = large_variant ? 17'h157fe : 17'h0abfe;
  wire [17:0] dec = {general_write_protect, retention_regulator_config,
    retention_regulator_allowed, emulator_pin_pair_select, programming_pin_pair_two,
    programming_pin_pair_three, emulator_select_invalid, windowed_watchdog_disable,
    watchdog_config_field, watchdog_enable_sleep, watchdog_window_invalid,
    watchdog_prescale_select, watchdog_postscale_select};
  wire [4:0] ctl = {boundary_scan_port_enable, general_code_protect, debug_boot,
    programming_pin_pair_one, watchdog_enable_run};
  wire [23:0] ratio = {watchdog_prescale_ratio, watchdog_postscale_ratio};

  cwl_loader DUT (.*);

  function [17:0] exp_dec(input [23:0] w, input s);
    begin
      exp_dec = {!w[12], w[10], !w[10], w[9:8], w[9:8] == 2'h2, w[9:8] == 2'h1,
        w[9:8] == 2'h0, w[7], w[6:5], w[6] && (w[5] || s), !w[7] && w[6:5] == 2'h0,
        w[4], w[3:0]};
    end
  endfunction

  function [4:0] exp_ctl(input [23:0] w, input s);
    begin
      exp_ctl = {w[14], !w[13], !w[11], w[9:8] == 2'h3, w[5] || (w[6] && s)};
    end
  endfunction

  function [23:0] exp_ratio(input [23:0] w);
    begin
      exp_ratio = {w[4] ? 8'h80 : 8'h20, 16'h0001 << w[3:0]};
    end
  endfunction

  task chk(input string nm, input [24:0] seen, input [24:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task tread(input [23:0] a, input [24:0] e);
    begin
      tbl_rd = 1'b1;
      tbl_addr = a;
      @(negedge clk);
      chk("table_read", {tbl_hit, tbl_rdata}, e);
    end
  endtask

  task complete_run;
    begin
      $display("Checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // ********
  // Flash model and stimulus
  // ********
  always @(posedge clk) begin
    if (reset) begin
      flash_data <= 24'h000000;
      rd_cnt <= 3'h0;
    end else begin
      // Word 1 sits only at its reserved location; other addresses read back their address
      flash_data <= flash_rd ? ((flash_addr == base) ? w1 : {7'h00, flash_addr}) :
        ~flash_data;
      if (flash_rd) begin
        chk("flash_addr", flash_addr, base - {rd_cnt, 1'b0});
        rd_cnt <= rd_cnt + 3'h1;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 4000);
    num_errors = num_errors + 1;
    complete_run;
  end

  initial begin
    {reset, large_variant, last_page_erase, tbl_rd, tbl_wr, watchdog_software_enable} = 6'h20;
    {tbl_addr, tbl_wdata, data_addr, w1} = 96'h0;
    num_errors = 0;
    samples_checked = 0;
    rnd = $urandom(32'h3421);
    repeat (20) @(negedge clk);
    chk("reset_state", {device_reset_hold, config_word_one}, 25'h1ffffff);
    for (i = 0; i < 12; i = i + 1) begin
      rnd = $urandom;
      reset = 1'b1;
      large_variant = i[0];
      last_page_erase = (i == 1);
      watchdog_software_enable = rnd[31];
      w1 = (i == 0) ? 24'hffffff : {9'h000, rnd[14:0]};
      w_eff = (i == 1) ? 24'h000000 : w1;
      data_addr = (i < 2) ? 24'h7fffff + i : rnd[23:0];
      @(negedge clk);
      reset = 1'b0;
      n = 0;
      while (device_reset_hold !== 1'b0 && n < 20) begin
        @(negedge clk);
        n = n + 1;
      end
      chk("load_reads", {load_busy, rd_cnt}, 4'h4);
      chk("config_word_one", config_word_one, {8'hff, w_eff[15:0]});
      chk("decode", dec, exp_dec(w_eff, rnd[31]));
      chk("decode_ctl", ctl, exp_ctl(w_eff, rnd[31]));
      chk("wdt_ratio", ratio, exp_ratio(w_eff));
      chk("data_blocked", data_cfg_blocked, data_addr >= 24'h800000);
      tbl_wr = 1'b1;
      tbl_addr = 24'hf80000;
      tbl_wdata = ~w1;
      @(negedge clk);
      tbl_wr = 1'b0;
      tread(24'hf80000, {9'h1ff, w_eff[15:0]});
      tread(24'hf80002, {9'h1ff, last_page_erase ? 16'h0000 : base[15:0] - 16'h0002});
      tread(24'hf80006, {9'h1ff, last_page_erase ? 16'h0000 : base[15:0] - 16'h0006});
      tread(24'hf80008, 25'h0);
      tbl_rd = 1'b0;
    end
    complete_run;
  end
endmodule // tb_cwl_loader
